// ==== hw/flash_sr_defines.svh ====
/*
 * constants of the status and block-protect logic: opcodes, status bit
 * positions and self-timed cycle times.
 * assumes a 100 MHz core clock; times are microseconds, counts derived.
 */
`ifndef FLASH_SR_DEFINES_SVH
`define FLASH_SR_DEFINES_SVH

// serial opcodes, shifted msb first
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_RD_STATUS 8'h05
`define OP_WR_STATUS 8'h01
`define OP_PAGE_WRITE 8'h02
`define OP_ERASE_SECTOR 8'hd8
`define OP_ERASE_BULK 8'hc7

// status byte layout
`define SR_WIP_BIT 0
`define SR_WEL_BIT 1
`define SR_BP_LSB 2

// byte counts a write-type command must end on
`define LEN_SHORT 3'h1
`define LEN_STATUS 3'h2
`define LEN_SECTOR 3'h4
`define LEN_PAGE_MIN 3'h5

// timing
`define CLK_PERIOD_NS 10
`define WS_TIME_US 5000
`define PAGE_TIME_US 1000
`define SE_TIME_US 100000
`define BE_TIME_US 1000000
`define US_TO_CYCLES(t) (((t) * 1000) / `CLK_PERIOD_NS)

`endif

// ==== hw/flash_sr_pkg.sv ====
/*
 * types shared by the status block: link states, cycle kinds and the
 * cycle request handed to the array datapath.
 * assumes nothing beyond a systemverilog compiler.
 */
package flash_sr_pkg;

    // serial link sequencing
    typedef enum {LK_IDLE, LK_CMD, LK_ARGS, LK_STATUS, LK_SKIP} link_state_t;

    // kind of self-timed cycle
    typedef enum logic [2:0] {CY_NONE, CY_PAGE, CY_SECTOR, CY_BULK, CY_STATUS} cycle_kind_t;

    // request issued to the array when a cycle starts
    typedef struct packed {
        cycle_kind_t kind;
        logic [23:0] addr;
        logic [2:0] bp;
    } cycle_cmd_t;

endpackage

// ==== hw/sector_guard.sv ====
/*
 * decodes the block-protect code into a protected top-of-array range and
 * tells whether a given sector falls in it.
 * assumes sectors is one of 4, 8, 32, 64 or 128; purely combinational.
 */
`timescale 1ns/1ps
module sector_guard #(
    parameter int SECTORS = 8,
    parameter int IDX_W = $clog2(SECTORS)
) (
    input wire logic [2:0] bp, // protect code, low bit first
    input wire logic [IDX_W-1:0] sector, // sector under test
    output logic hit // sector is protected
);
    logic [8:0] prot_n; // number of protected top sectors

    // protected count per variant; every range ends at the top sector
    always_comb begin
        prot_n = 9'h000;
        if (SECTORS == 4) begin
            prot_n = (bp[1:0] == 2'h3) ? 9'h004 : {7'h00, bp[1:0]}; // RL7
        end else if (SECTORS == 128) begin
            if (bp != 3'h0) begin
                prot_n = 9'h001 << bp; // RL10
            end
        end else if (bp != 3'h0) begin
            prot_n = 9'h001 << (bp - 3'h1); // RL8 RL9 RL11
            if (prot_n > 9'(SECTORS)) begin
                prot_n = 9'(SECTORS); // codes beyond the array mean all
            end
        end
    end

    // inside the range when index plus count reaches the array size
    always_comb begin
        hit = (9'(sector) + prot_n) >= 9'(SECTORS); // RL6
    end
endmodule

// ==== hw/flash_status_block_protect.sv ====
/*
 * status byte and block-protect logic of a serial flash behind its link pins.
 * assumes the array acts on cycle_start/cycle_cmd, protect bits on nv_bp_in.
 */
// Functional notes
// RL1 - busy flag high exactly while cycle runs
// RL2 - latch clear refuses every write or erase
// RL3 - host sets latch before each write
// RL4 - protect bits non-volatile, select shielded region
// RL5 - bulk erase only with all protect zero
// RL6 - protected sectors refuse write and erase
// RL7 - four-sector decode: none, 3, 2-3, all
// RL8 - eight-sector decode: none, 7, 6-7, 4-7, all
// RL9 - 32-sector decode, top powers, 11x all
// RL10 - 128-sector decode from two sectors up
// RL11 - 64-sector decode from one sector up
// RL12 - status readable even during a cycle
// RL13 - host polls busy bit before next command
// RL14 - status byte repeats live while clocked
// RL15 - latch in bit one, set/cleared by commands
// RL16 - latch cleared at reset and cycle end
// RL17 - status read opcode 05, msb first
// RL18 - protect bits 2 to 4, upper zero
// RL19 - refused commands start nothing, stay silent
`timescale 1ns/1ps
`include "flash_sr_defines.svh"
module flash_status_block_protect
    import flash_sr_pkg::*;
#(
    parameter int SECTORS = 8,
    parameter int SECTOR_ADDR_LSB = 16,
    parameter int STATUS_CYCLES = `US_TO_CYCLES(`WS_TIME_US),
    parameter int PAGE_CYCLES = `US_TO_CYCLES(`PAGE_TIME_US),
    parameter int SECTOR_CYCLES = `US_TO_CYCLES(`SE_TIME_US),
    parameter int BULK_CYCLES = `US_TO_CYCLES(`BE_TIME_US)
) (
    input wire logic clk, // core clock
    input wire logic rst, // synchronous reset, power-up
    input wire logic sclk, // serial clock from host
    input wire logic cs_n, // chip select, active low
    input wire logic sdi, // serial data in
    output logic sdo, // serial data out
    output logic sdo_oe, // sdo driven
    input wire logic [2:0] nv_bp_in, // stored protect bits
    output logic [2:0] nv_bp_out, // protect bits to store
    output logic nv_bp_we, // store strobe, one cycle
    output logic cycle_start, // cycle begins, one cycle
    output cycle_cmd_t cycle_cmd, // cycle request
    output logic wip, // write in progress
    output logic wel // write enable latch
);
    localparam int IDX_W = $clog2(SECTORS);
    localparam logic [2:0] BP_MASK = (SECTORS == 4) ? 3'h3 : 3'h7; // only two bits when four
    // pin synchroniser, order {sclk, cs_n, sdi}
    logic [2:0] s1_reg, s2_reg, s3_reg, flt_reg, flt_next;
    logic sclk_rise, sclk_fall, cs_rise, sel, din;
    always_comb begin
        // a change counts once the second and third stages agree
        flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg));
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= 3'h2;
            s2_reg <= 3'h2;
            s3_reg <= 3'h2;
            flt_reg <= 3'h2;
        end else begin
            s1_reg <= {sclk, cs_n, sdi};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            flt_reg <= flt_next;
        end
    end
    assign sclk_rise = flt_next[2] & ~flt_reg[2];
    assign sclk_fall = ~flt_next[2] & flt_reg[2];
    assign cs_rise = flt_next[1] & ~flt_reg[1];
    assign sel = ~flt_next[1];
    assign din = flt_next[0];
    // link state
    link_state_t lk_reg, lk_next;
    logic [7:0] sh_reg, sh_next; // incoming shifter, holds the last byte
    logic [2:0] bit_reg, bit_next; // bit within byte
    logic [2:0] byte_reg, byte_next; // bytes taken, saturating
    logic [7:0] op_reg, op_next; // opcode
    logic [23:0] addr_reg, addr_next; // address bytes
    logic [7:0] tx_reg, tx_next; // outgoing status
    logic sdo_reg, sdo_next, oe_reg, oe_next; // serial output and its enable
    logic [7:0] byte_in, status_now; // byte completing now, live status
    // cycle state
    logic wip_reg, wip_next, wel_reg, wel_next;
    logic [2:0] bp_reg, bp_next, nvbp_reg, nvbp_next;
    logic [31:0] cnt_reg, cnt_next;
    cycle_cmd_t cmd_reg, cmd_next;
    logic start_reg, start_next, nvwe_reg, nvwe_next;
    logic hit, eval; // sector protected, command ends now
    // live status byte; spare bits read zero
    assign status_now = {3'h0, bp_reg, wel_reg, wip_reg}; // RL18 RL15
    assign byte_in = {sh_reg[6:0], din};
    sector_guard #(.SECTORS(SECTORS), .IDX_W(IDX_W)) u_guard (
        .bp(bp_reg),
        .sector(addr_reg[SECTOR_ADDR_LSB +: IDX_W]),
        .hit(hit)
    );
    // serial shifting and status streaming
    always_comb begin
        lk_next = lk_reg;
        sh_next = sh_reg;
        bit_next = bit_reg;
        byte_next = byte_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        tx_next = tx_reg;
        sdo_next = sdo_reg;
        oe_next = oe_reg;
        if (!sel) begin
            // deselect ends any sequence and floats the output
            lk_next = LK_IDLE;
            oe_next = 1'b0;
            sdo_next = 1'b0;
        end else if (lk_reg == LK_IDLE) begin
            lk_next = LK_CMD;
            bit_next = 3'h0;
            byte_next = 3'h0;
        end else if (lk_reg == LK_STATUS) begin
            if (sclk_fall) begin
                // reload at each byte end so the flags stay live
                sdo_next = tx_reg[7]; // RL14
                oe_next = 1'b1;
                bit_next = bit_reg + 3'h1;
                tx_next = (bit_reg == 3'h7) ? status_now : {tx_reg[6:0], 1'b0}; // RL14
            end
        end else if (sclk_rise) begin
            sh_next = byte_in;
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
                byte_next = (byte_reg == 3'h7) ? byte_reg : byte_reg + 3'h1;
                if (lk_reg == LK_CMD) begin
                    op_next = byte_in;
                    if (byte_in == `OP_RD_STATUS) begin
                        lk_next = LK_STATUS; // RL17 RL12
                        tx_next = status_now;
                        bit_next = 3'h0;
                    end else begin
                        // while busy only status reads are honoured
                        lk_next = wip_reg ? LK_SKIP : LK_ARGS;
                    end
                end else if (byte_reg <= 3'h3) begin
                    addr_next = {addr_reg[15:0], byte_in};
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            lk_reg <= LK_IDLE;
            sh_reg <= 8'h00;
            bit_reg <= 3'h0;
            byte_reg <= 3'h0;
            op_reg <= 8'h00;
            addr_reg <= 24'h000000;
            tx_reg <= 8'h00;
            sdo_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            lk_reg <= lk_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            tx_reg <= tx_next;
            sdo_reg <= sdo_next;
            oe_reg <= oe_next;
        end
    end
    // a write-type command acts only when select rises on a byte boundary
    assign eval = cs_rise && (lk_reg == LK_ARGS) && (bit_reg == 3'h0);
    // latch, protect bits and self-timed cycle
    always_comb begin
        wip_next = wip_reg;
        wel_next = wel_reg;
        bp_next = bp_reg;
        cnt_next = cnt_reg;
        cmd_next = cmd_reg;
        start_next = 1'b0;
        nvwe_next = 1'b0;
        nvbp_next = nvbp_reg;
        if (wip_reg) begin
            cnt_next = cnt_reg - 32'h1;
            if (cnt_reg <= 32'h1) begin
                wip_next = 1'b0; // RL1
                wel_next = 1'b0; // RL16
                if (cmd_reg.kind == CY_STATUS) begin
                    bp_next = cmd_reg.bp; // RL4
                    nvbp_next = cmd_reg.bp;
                    nvwe_next = 1'b1;
                end
            end
        end else if (eval) begin
            cmd_next.addr = addr_reg;
            cmd_next.bp = bp_reg;
            cmd_next.kind = CY_NONE;
            unique case (op_reg)
                `OP_WR_ENABLE: wel_next = (byte_reg == `LEN_SHORT) ? 1'b1 : wel_reg; // RL15
                `OP_WR_DISABLE: wel_next = (byte_reg == `LEN_SHORT) ? 1'b0 : wel_reg; // RL15
                `OP_WR_STATUS: begin
                    if (byte_reg == `LEN_STATUS) begin
                        cmd_next.kind = CY_STATUS;
                        cmd_next.bp = sh_reg[`SR_BP_LSB +: 3] & BP_MASK; // data byte came last
                    end
                end
                `OP_PAGE_WRITE: begin
                    if (byte_reg >= `LEN_PAGE_MIN && !hit) begin // RL6
                        cmd_next.kind = CY_PAGE;
                    end
                end
                `OP_ERASE_SECTOR: begin
                    if (byte_reg == `LEN_SECTOR && !hit) begin // RL6
                        cmd_next.kind = CY_SECTOR;
                    end
                end
                `OP_ERASE_BULK: begin
                    if (byte_reg == `LEN_SHORT && bp_reg == 3'h0) begin // RL5
                        cmd_next.kind = CY_BULK;
                    end
                end
                default: cmd_next.kind = CY_NONE; // unknown opcodes are ignored
            endcase
            // refused requests leave everything as it was
            if (cmd_next.kind != CY_NONE && wel_reg) begin // RL2 RL19
                wip_next = 1'b1; // RL1
                start_next = 1'b1;
                unique case (cmd_next.kind)
                    CY_STATUS: cnt_next = 32'(STATUS_CYCLES);
                    CY_PAGE: cnt_next = 32'(PAGE_CYCLES);
                    CY_SECTOR: cnt_next = 32'(SECTOR_CYCLES);
                    default: cnt_next = 32'(BULK_CYCLES);
                endcase
            end else begin
                cmd_next = cmd_reg;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            wip_reg <= 1'b0;
            wel_reg <= 1'b0; // RL16
            bp_reg <= nv_bp_in & BP_MASK; // RL4
            cnt_reg <= 32'h0;
            cmd_reg <= '0;
            start_reg <= 1'b0;
            nvwe_reg <= 1'b0;
            nvbp_reg <= 3'h0;
        end else begin
            wip_reg <= wip_next;
            wel_reg <= wel_next;
            bp_reg <= bp_next;
            cnt_reg <= cnt_next;
            cmd_reg <= cmd_next;
            start_reg <= start_next;
            nvwe_reg <= nvwe_next;
            nvbp_reg <= nvbp_next;
        end
    end
    assign sdo = sdo_reg;
    assign sdo_oe = oe_reg;
    assign nv_bp_out = nvbp_reg;
    assign nv_bp_we = nvwe_reg;
    assign cycle_start = start_reg;
    assign cycle_cmd = cmd_reg;
    assign wip = wip_reg;
    assign wel = wel_reg;
    a_wip_rise: assert property (@(posedge clk) disable iff (rst) // RL1
        $rose(wip_reg) |-> start_reg) else $error("busy rose without a start");
    a_wip_hold: assert property (@(posedge clk) disable iff (rst) // RL1
        wip_reg && cnt_reg > 32'h1 |=> wip_reg) else $error("busy dropped early");
    a_cycle_end: assert property (@(posedge clk) disable iff (rst) // RL16
        wip_reg && cnt_reg == 32'h1 |=> !wip_reg && !wel_reg) else $error("cycle end wrong");
    a_wel_gate: assert property (@(posedge clk) disable iff (rst) // RL2
        start_reg |-> $past(wel_reg) && !$past(wip_reg)) else $error("start without latch");
    a_bulk_guard: assert property (@(posedge clk) disable iff (rst) // RL5
        start_reg && cmd_reg.kind == CY_BULK |-> $past(bp_reg) == 3'h0)
        else $error("bulk erase while protected");
    a_prot_block: assert property (@(posedge clk) disable iff (rst) // RL6
        start_reg && (cmd_reg.kind == CY_PAGE || cmd_reg.kind == CY_SECTOR) |-> !$past(hit))
        else $error("protected sector accepted");
    a_bp_change: assert property (@(posedge clk) disable iff (rst) // RL4
        $changed(bp_reg) |-> $past(wip_reg) && $past(cmd_reg.kind) == CY_STATUS && nvwe_reg)
        else $error("protect bits changed outside status cycle");
    a_status_shift: assert property (@(posedge clk) disable iff (rst) // RL14
        lk_reg == LK_STATUS && sel && sclk_fall |=> oe_reg && sdo_reg == $past(tx_reg[7]))
        else $error("status bit not shifted");
    a_status_op: assert property (@(posedge clk) disable iff (rst) // RL17
        lk_reg == LK_CMD && sel && sclk_rise && bit_reg == 3'h7 && byte_in == `OP_RD_STATUS
        |=> lk_reg == LK_STATUS && tx_reg == $past(status_now)) else $error("status read missed");
    a_wel_set: assert property (@(posedge clk) disable iff (rst) // RL15
        eval && !wip_reg && op_reg == `OP_WR_ENABLE && byte_reg == `LEN_SHORT |=> wel_reg)
        else $error("enable latch not set");
endmodule

// ==== tb/flash_host_model.sv ====
/*
 * behavioural host controller for the serial link of the status block:
 * selects the device, shifts bytes out msb first, reads bytes back.
 * assumes the core clock drives its timing; link clock is 160 ns.
 */
`timescale 1ns/1ps
`include "flash_sr_defines.svh"
module flash_host_model (
    input wire logic clk, // core clock, paces the link
    output logic sclk, // serial clock, still outside frames
    output logic cs_n, // chip select, active low
    output logic sdi, // serial data to device
    input wire logic sdo, // serial data from device
    input wire logic sdo_oe // device drives sdo
);
    // idle link at time zero
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // half of one link period, inputs move just after an edge
    task automatic half();
        repeat (8) @(posedge clk);
        #1;
    endtask

    // one frame: nb bytes out, then nr bytes in, last three kept
    task automatic frame(input logic [39:0] tx, input int nb, input int nr,
                         output logic [23:0] rx);
        rx = 24'h0;
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        for (int i = 0; i < (nb + nr) * 8; i++) begin
            // bits msb first; during readback the line carries no data
            if (i < nb * 8)
                sdi = tx[39 - i];
            else
                sdi = ~sdi;
            half();
            sclk = 1'b1;
            // undriven sdo reads unknown so a missing enable shows up
            if (i >= nb * 8)
                rx = {rx[22:0], sdo_oe ? sdo : 1'bx};
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        sdi = ~sdi; // released line must not keep its last bit
        half();
    endtask

    // poll the busy bit before any further command, bounded
    task automatic poll(output logic [7:0] st);
        logic [23:0] rx;
        st = 8'hff;
        for (int n = 0; n < 40 && st[0] !== 1'b0; n++) begin
            frame({`OP_RD_STATUS, 32'h0}, 1, 1, rx);
            st = rx[7:0];
        end
    endtask
endmodule

// ==== tb/flash_status_block_protect_tb_top.sv ====
/*
 * self-checking bench of the status and block-protect logic, eight sectors.
 * assumes the host model file is compiled first; cycle times are shortened.
 */
`timescale 1ns/1ps
`include "flash_sr_defines.svh"
module flash_status_block_protect_tb_top;
    import flash_sr_pkg::*;
    localparam int SECTOR_CYC = 15; // short sector erase
    localparam int STATUS_CYC = 20; // short status write
    localparam int BULK_CYC = 300; // long enough to read status inside
    logic clk, rst, sclk, cs_n, sdi, sdo, sdo_oe, nv_bp_we, cycle_start, wip, wel;
    logic [2:0] nv_bp_in, nv_bp_out, last_nv;
    cycle_cmd_t cycle_cmd, last_cmd;
    int mismatches, checks, starts, wip_run, wip_len;

    flash_status_block_protect #(.SECTORS(8), .SECTOR_ADDR_LSB(16),
        .STATUS_CYCLES(STATUS_CYC), .PAGE_CYCLES(10), .SECTOR_CYCLES(SECTOR_CYC),
        .BULK_CYCLES(BULK_CYC)) dut (.clk(clk), .rst(rst), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .nv_bp_in(nv_bp_in),
        .nv_bp_out(nv_bp_out), .nv_bp_we(nv_bp_we), .cycle_start(cycle_start),
        .cycle_cmd(cycle_cmd), .wip(wip), .wel(wel));
    flash_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe));

    // free-running core clock
    always #5 clk = ~clk;

    // records cycle starts, stores and the length of each busy span
    always @(posedge clk) begin
        if (cycle_start === 1'b1) begin
            starts++;
            last_cmd = cycle_cmd;
        end
        if (nv_bp_we === 1'b1)
            last_nv = nv_bp_out;
        if (wip === 1'b1)
            wip_run++;
        else if (wip_run != 0) begin
            wip_len = wip_run;
            wip_run = 0;
        end
    end

    // single comparison of any design value
    task automatic cmp(input logic [29:0] got, input logic [29:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // protected range of the eight-sector part
    function automatic logic prot(input logic [2:0] c, input int s);
        if (c[2])
            return 1'b1;
        if (c == 3'h0)
            return 1'b0;
        return s >= 8 - (1 << (c - 1));
    endfunction

    // issue a command, wait until idle, check whether a cycle began
    task automatic run_op(input logic [39:0] tx, input int nb, input logic go,
                          output logic [7:0] st);
        int s0;
        logic [23:0] rx;
        s0 = starts;
        host.frame(tx, nb, 0, rx);
        host.poll(st);
        cmp(30'(starts - s0), {29'h0, go});
    endtask

    // latch set, the host's duty before every write
    task automatic wren();
        logic [23:0] rx;
        host.frame({`OP_WR_ENABLE, 32'h0}, 1, 0, rx);
    endtask

    // read one status byte
    task automatic status(output logic [7:0] st);
        logic [23:0] rx;
        host.frame({`OP_RD_STATUS, 32'h0}, 1, 1, rx);
        st = rx[7:0];
    endtask

    // protect code from reset, repeated bytes, upper bits zero
    task automatic reset_status();
        logic [23:0] rx;
        host.frame({`OP_RD_STATUS, 32'h0}, 1, 2, rx);
        cmp(30'(rx[15:8]), 30'h0c);
        cmp(30'(rx[7:0]), 30'h0c);
    endtask

    // cleared latch refuses, enable and disable move bit one
    task automatic latch_gate();
        logic [7:0] st;
        logic [23:0] rx;
        run_op({`OP_ERASE_SECTOR, 32'h0}, 4, 1'b0, st);
        cmp(30'(st), 30'h0c);
        wren();
        status(st);
        cmp(30'(st), 30'h0e);
        cmp(30'(wel), 30'h1);
        host.frame({`OP_WR_DISABLE, 32'h0}, 1, 0, rx);
        status(st);
        cmp(30'(st), 30'h0c);
        cmp(30'(wel), 30'h0);
    endtask

    // protected sector and bulk refused, open sector erased and timed
    task automatic guard_timing();
        logic [7:0] st;
        wren();
        run_op({`OP_ERASE_SECTOR, 24'h040000, 8'h0}, 4, 1'b0, st);
        cmp(30'(st), 30'h0e);
        run_op({`OP_ERASE_BULK, 32'h0}, 1, 1'b0, st);
        run_op({`OP_ERASE_SECTOR, 24'h030000, 8'h0}, 4, 1'b1, st);
        cmp(30'(st), 30'h0c);
        cmp(last_cmd, {CY_SECTOR, 24'h030000, 3'h3});
        cmp(30'(wip_len), 30'(SECTOR_CYC));
    endtask

    // write a protect code and see it stored and reported
    task automatic set_bp(input logic [2:0] c);
        logic [7:0] st;
        wren();
        run_op({`OP_WR_STATUS, 3'h0, c, 2'h0, 24'h0}, 2, 1'b1, st);
        cmp(30'(last_nv), 30'(c));
        cmp(30'(st), 30'({c, 2'h0}));
        cmp(30'(wip_len), 30'(STATUS_CYC));
    endtask

    // every protect code against the boundary sectors
    task automatic protect_table();
        int secs[5] = '{0, 3, 4, 6, 7};
        logic [7:0] st;
        for (int c = 0; c < 8; c++) begin
            set_bp(3'(c));
            foreach (secs[k]) begin
                wren();
                run_op({`OP_PAGE_WRITE, 5'h0, 3'(secs[k]), 24'h00a5}, 5,
                       ~prot(3'(c), secs[k]), st);
            end
        end
    endtask

    // bulk erase with no protection, status streamed live meanwhile
    task automatic bulk_live();
        logic [23:0] rx;
        logic [7:0] st;
        set_bp(3'h0);
        wren();
        host.frame({`OP_ERASE_BULK, 32'h0}, 1, 0, rx);
        host.frame({`OP_RD_STATUS, 32'h0}, 1, 3, rx);
        cmp(30'(rx[23:16]), 30'h03);
        cmp(30'(rx[7:0]), 30'h00);
        host.poll(st);
        cmp(30'(last_cmd.kind), 30'(CY_BULK));
        cmp(30'(wip_len), 30'(BULK_CYC));
    endtask

    // verdict and end of run
    task automatic close_out();
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // reset with a stored code, then the scenarios in turn
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        nv_bp_in = 3'h3;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        nv_bp_in = 3'h6; // later changes must not leak into the status
        reset_status();
        latch_gate();
        guard_timing();
        protect_table();
        bulk_live();
        close_out();
    end

    // hang guard, well beyond the expected run length
    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule
